// File: rbsm_pkg.sv
package rbsm_pkg;

  // ------------------------------------------------------------
  // Buffer geometry
  // ------------------------------------------------------------
  // Word address bits: base memory, then enlarged build option
  localparam int RBSM_AW_BASE = 18;
  localparam int RBSM_AW_BIG = 20;
  // Largest page offset width carried in the host write struct
  localparam int RBSM_OFS_W = 18;
  // Shortest telemetry message, in 16-bit words
  localparam logic [15:0] RBSM_MSG_MIN = 16'h0002;
  // Drives on one disk bus, at most
  localparam logic [2:0] RBSM_DPB_MAX = 3'h4;

  // ------------------------------------------------------------
  // Command/status register
  // ------------------------------------------------------------
  localparam logic [7:0] RBSM_CMD_OFS = 8'h04;
  localparam int RBSM_B_EN = 0;
  localparam int RBSM_B_ON = 1;
  localparam int RBSM_B_OFF = 2;
  localparam int RBSM_B_DUAL = 3;
  localparam int RBSM_B_HSRC = 4;
  localparam int RBSM_B_MM = 5;
  localparam int RBSM_B_OVF = 6;
  localparam int RBSM_B_REC = 7;
  localparam int RBSM_B_FILL = 8;
  localparam int RBSM_B_DISK = 10;
  localparam int RBSM_B_PEND = 12;
  localparam int RBSM_B_NOPG = 13;
  localparam logic [15:0] RBSM_CMD_RST = 16'h0000;

  // ------------------------------------------------------------
  // Carriers and states
  // ------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [RBSM_OFS_W-1:0] off;
    logic [31:0] data;
  } rbsm_hwr_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } rbsm_disk_type;

  typedef enum logic [1:0] {
    DK_IDLE,
    DK_RD,
    DK_WAIT,
    DK_OUT
  } rbsm_dk_state_type;

endpackage : rbsm_pkg

// File: rbsm_mem.sv
`timescale 1ns/1ps
module rbsm_mem #(
  parameter int AW = 18,
  parameter int DW = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read port
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  // Write side
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read side
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : rbsm_mem

// File: rbsm_top.sv
// Summary of operation
// - Buffer memory 1MB, build option 4MB
// - Four pages, forming and completed records
// - Telemetry messages with time header, 16-bit count
// - Block up to one page long
// - Dual bus alternates completed blocks
// - Interrupt processor on each completed block
// - Disk transfer only to ready drive
// - Odd drives bus one, even bus two
// - One to four drives per bus
// - Single bus mode, no alternation
// - Interrupt host at each DMA end
// - Interrupt processor at each DMA end
// - First record completed after start recorded
// - After stop, one more record, then none
// - Page base address, 256k byte page, 1M byte in build option
// - Record length counted in 32-bit words
// - Full page rotates to next empty page
// - Memory-mapped record to disk only recording
// - Dual-ported memory, host read window
`timescale 1ns/1ps
module rbsm_top import rbsm_pkg::*; #(
  parameter bit BIG = 1'b0,
  parameter int AW = BIG ? RBSM_AW_BIG : RBSM_AW_BASE,
  parameter logic [31:0] WIN_BASE = 32'h0000_0000
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command/status register
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // Record configuration
  input wire logic [AW-2:0] rec_len,
  input wire logic [15:0] msg_len,
  input wire logic [2:0] drv_per_bus,
  // Telemetry stream
  input wire logic ts_valid,
  input wire logic [15:0] ts_data,
  input wire logic [31:0] ts_time,
  // Host writes and read window
  input wire rbsm_hwr_type host_wr,
  input wire logic hr_req,
  input wire logic [AW-1:0] hr_addr,
  output logic hr_valid,
  output logic [31:0] hr_data,
  // Disk transfer control
  input wire logic xfer_go,
  input wire logic [1:0] drv_ready,
  input wire logic [1:0] dk_ready,
  output rbsm_disk_type [1:0] dk_out,
  output logic xfer_done,
  output logic tgt_bus,
  output logic [3:0] tgt_drive,
  // Events and page address
  output logic blk_irq,
  output logic host_irq,
  output logic [31:0] mm_page_addr
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  localparam int PW = AW - 2;
  localparam logic [PW:0] PG_WORDS = {1'b1, {PW{1'b0}}};

  logic rst_s1_q, srst_n;
  logic en_q, dual_q, hsrc_q, mm_q, ovf_q, rec_q, stop_q;
  logic cmd_wr, nopage_q, half_q, half_d, wr_req, wr_en, drop;
  logic blk_done, free_nxt, dk_clr, start, rd_issue, word_ok;
  logic last_word, ts_last, xfer_done_q, mem_re;
  logic [15:0] lo_q, lo_d, mc_q, mc_d, msg_eff, status;
  logic [31:0] wr_data, rdata;
  logic [PW-1:0] wr_off;
  logic [PW:0] wc_q, rc_q, eff_len;
  logic [1:0] fill_q, nxt, dk_q;
  logic [3:0] full_q;
  logic [2:0] pos_q, dpb;
  logic [3:0] period;
  logic bs_q;
  rbsm_dk_state_type ds_q;

  // ------------------------------------------------------------
  // Reset release and register port
  // ------------------------------------------------------------
  // Two-stage reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      srst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      srst_n <= rst_s1_q;
    end
  end

  assign cmd_wr = reg_wr && (reg_addr == RBSM_CMD_OFS);

  // Mode bits and sticky overflow; a new drop beats the clear
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      {en_q, dual_q, hsrc_q, mm_q, ovf_q} <= '0;
    end else begin
      if (cmd_wr) begin
        en_q <= reg_wdata[RBSM_B_EN];
        dual_q <= reg_wdata[RBSM_B_DUAL];
        hsrc_q <= reg_wdata[RBSM_B_HSRC];
        mm_q <= reg_wdata[RBSM_B_MM];
      end
      if (drop) begin
        ovf_q <= 1'b1;
      end else if (cmd_wr && reg_wdata[RBSM_B_OVF]) begin
        ovf_q <= 1'b0;
      end
    end
  end

  // Status word
  always_comb begin
    status = RBSM_CMD_RST;
    status[RBSM_B_EN] = en_q;
    status[RBSM_B_DUAL] = dual_q;
    status[RBSM_B_HSRC] = hsrc_q;
    status[RBSM_B_MM] = mm_q;
    status[RBSM_B_OVF] = ovf_q;
    status[RBSM_B_REC] = rec_q;
    status[RBSM_B_FILL+:2] = fill_q;
    status[RBSM_B_DISK+:2] = dk_q;
    status[RBSM_B_PEND] = full_q[dk_q];
    status[RBSM_B_NOPG] = nopage_q;
  end

  // Read data, zero for any other address
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      reg_rdata <= RBSM_CMD_RST;
    end else if (reg_rd) begin
      reg_rdata <= (reg_addr == RBSM_CMD_OFS) ? status : RBSM_CMD_RST;
    end
  end

  // ------------------------------------------------------------
  // Record formation
  // ------------------------------------------------------------
  // block length clamped to one page
  always_comb begin
    eff_len = rec_len;
    if (rec_len == '0) begin
      eff_len = {{PW{1'b0}}, 1'b1};
    end else if (rec_len > PG_WORDS) begin
      eff_len = PG_WORDS;
    end
  end

  assign msg_eff = (msg_len < RBSM_MSG_MIN) ? RBSM_MSG_MIN : msg_len;
  assign ts_last = (mc_q + 16'h0001) >= msg_eff;

  always_comb begin
    wr_req = 1'b0;
    wr_data = ts_time;
    wr_off = wc_q[PW-1:0];
    mc_d = mc_q;
    half_d = half_q;
    lo_d = lo_q;
    if (en_q && !hsrc_q && ts_valid) begin
      mc_d = ts_last ? 16'h0000 : mc_q + 16'h0001;
      if (mc_q == 16'h0000) begin
        wr_req = 1'b1;
        half_d = 1'b1;
        lo_d = ts_data;
      end else if (half_q) begin
        wr_req = 1'b1;
        wr_data = {ts_data, lo_q};
        half_d = 1'b0;
      end else if (ts_last) begin
        wr_req = 1'b1;
        wr_data = {16'h0000, ts_data};
      end else begin
        half_d = 1'b1;
        lo_d = ts_data;
      end
    end else if (en_q && hsrc_q && host_wr.valid) begin
      wr_req = 1'b1;
      wr_data = host_wr.data;
      if (mm_q) begin
        wr_off = host_wr.off[PW-1:0];
      end
    end
  end

  // Telemetry message state
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      mc_q <= 16'h0000;
      half_q <= 1'b0;
      lo_q <= 16'h0000;
    end else begin
      mc_q <= mc_d;
      half_q <= half_d;
      lo_q <= lo_d;
    end
  end

  // words dropped while no page is free
  assign wr_en = wr_req && !nopage_q;
  assign drop = wr_req && nopage_q;
  assign blk_done = wr_en && ((wc_q + 1'b1) == eff_len);
  assign nxt = fill_q + 2'd1;
  assign free_nxt = !full_q[nxt] || (dk_clr && dk_q == nxt);

  // ------------------------------------------------------------
  // Page rotation and record gating
  // ------------------------------------------------------------
  // Page ownership: fill page, queued full pages
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      fill_q <= 2'd0;
      nopage_q <= 1'b0;
      full_q <= 4'h0;
      wc_q <= '0;
    end else begin
      if (dk_clr) begin
        full_q[dk_q] <= 1'b0;
      end
      if (blk_done) begin
        wc_q <= '0;
        if (rec_q) begin
          full_q[fill_q] <= 1'b1;
        end
        if (free_nxt || !rec_q) begin
          fill_q <= free_nxt ? nxt : fill_q;
          nopage_q <= !free_nxt && rec_q;
        end else begin
          nopage_q <= 1'b1;
        end
      end else if (nopage_q && free_nxt) begin
        fill_q <= nxt;
        nopage_q <= 1'b0;
      end else if (wr_en) begin
        wc_q <= wc_q + 1'b1;
      end
    end
  end

  // Recording on/off with one-record stop latency
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      rec_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      // last record after stop still kept
      if (blk_done && stop_q) begin
        rec_q <= 1'b0;
        stop_q <= 1'b0;
      end
      if (cmd_wr && reg_wdata[RBSM_B_ON]) begin
        rec_q <= 1'b1;
        stop_q <= 1'b0;
      end else if (cmd_wr && reg_wdata[RBSM_B_OFF] && rec_q) begin
        stop_q <= 1'b1;
      end
    end
  end

  // Event pulses and page window address
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      blk_irq <= 1'b0;
      host_irq <= 1'b0;
      mm_page_addr <= WIN_BASE;
    end else begin
      blk_irq <= blk_done;
      host_irq <= blk_done && hsrc_q && !mm_q;
      mm_page_addr <= WIN_BASE + (32'(fill_q) << (PW + 2));
    end
  end

  // ------------------------------------------------------------
  // Buffer memory
  // ------------------------------------------------------------
  // host window has priority on read port
  assign rd_issue = (ds_q == DK_RD) && !hr_req;
  assign mem_re = rd_issue || hr_req;

  rbsm_mem #(.AW(AW), .DW(32)) u_mem (
    .clk(mclk),
    .rst_n(srst_n),
    .we(wr_en),
    .waddr({fill_q, wr_off}),
    .wdata(wr_data),
    .re(mem_re),
    .raddr(hr_req ? hr_addr : {dk_q, rc_q[PW-1:0]}),
    .rdata(rdata)
  );

  assign hr_data = rdata;

  // Host read strobe
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      hr_valid <= 1'b0;
    end else begin
      hr_valid <= hr_req;
    end
  end

  // ------------------------------------------------------------
  // Disk transfer engine
  // ------------------------------------------------------------
  // start only to a ready drive
  assign start = (ds_q == DK_IDLE) && xfer_go && full_q[dk_q] &&
                 drv_ready[tgt_bus] && !xfer_done_q;
  assign word_ok = (ds_q == DK_OUT) && dk_ready[bs_q];
  assign last_word = (rc_q + 1'b1) == eff_len;
  assign dk_clr = word_ok && last_word;

  // Page read sequencer
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      ds_q <= DK_IDLE;
      rc_q <= '0;
      bs_q <= 1'b0;
      dk_q <= 2'd0;
      xfer_done_q <= 1'b0;
    end else begin
      xfer_done_q <= dk_clr;
      case (ds_q)
        DK_IDLE: begin
          if (start) begin
            ds_q <= DK_RD;
            rc_q <= '0;
            bs_q <= tgt_bus;
          end else if (!full_q[dk_q] && dk_q != fill_q) begin
            // Step over pages reused while not recording
            dk_q <= dk_q + 2'd1;
          end
        end
        DK_RD: begin
          if (rd_issue) begin
            ds_q <= DK_WAIT;
          end
        end
        DK_WAIT: ds_q <= DK_OUT;
        DK_OUT: begin
          if (dk_clr) begin
            ds_q <= DK_IDLE;
            dk_q <= dk_q + 2'd1;
          end else if (word_ok) begin
            ds_q <= DK_RD;
            rc_q <= rc_q + 1'b1;
          end
        end
        default: ds_q <= DK_IDLE;
      endcase
    end
  end

  assign xfer_done = xfer_done_q;

  // one output path per disk bus
  for (genvar b = 0; b < 2; b++) begin : g_bus
    always_ff @(posedge mclk or negedge srst_n) begin
      if (!srst_n) begin
        dk_out[b] <= '0;
      end else if (bs_q == 1'(b)) begin
        if (ds_q == DK_WAIT) begin
          dk_out[b].valid <= 1'b1;
          dk_out[b].data <= rdata;
          dk_out[b].last <= last_word;
        end else if (word_ok) begin
          dk_out[b].valid <= 1'b0;
        end
      end else begin
        dk_out[b].valid <= 1'b0;
      end
    end
  end

  // one to four drives per bus
  assign dpb = (drv_per_bus == 3'h0) ? 3'h1 :
               (drv_per_bus > RBSM_DPB_MAX) ? RBSM_DPB_MAX : drv_per_bus;
  assign period = dual_q ? {dpb, 1'b0} : {1'b0, dpb};

  // Block position and target drive
  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      pos_q <= 3'h0;
      tgt_bus <= 1'b0;
      tgt_drive <= 4'h1;
    end else begin
      if ({1'b0, pos_q} >= period) begin
        pos_q <= 3'h0;
      end else if (dk_clr) begin
        pos_q <= ({1'b0, pos_q} + 4'h1 == period) ? 3'h0 : pos_q + 3'h1;
      end
      // odd drives bus one, even bus two
      tgt_bus <= dual_q && pos_q[0];
      tgt_drive <= dual_q ? 4'(pos_q) + 4'h1 : 4'({pos_q, 1'b1});
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!srst_n);

  sequence s_word;
    ds_q == DK_WAIT ##1 ds_q == DK_OUT;
  endsequence

  a_ovf_sticky: assert property (
    ovf_q && !cmd_wr |=> ovf_q) else $error("overflow flag lost");
  a_drop_ovf: assert property (
    drop |=> ovf_q && !$past(wr_en)) else $error("drop without flag");
  a_page_rot: assert property (
    blk_done && free_nxt |=> fill_q == $past(nxt))
    else $error("page not rotated");
  a_blk_event: assert property (
    blk_done |=> blk_irq ##1 (!blk_irq || $past(blk_done)))
    else $error("block event missing");
  a_host_event: assert property (
    host_irq |-> $past(blk_done && hsrc_q && !mm_q))
    else $error("stray host event");
  a_ready_start: assert property (
    ds_q == DK_IDLE ##1 ds_q == DK_RD |-> $past(drv_ready[tgt_bus]))
    else $error("start to busy drive");
  a_word_seq: assert property (
    rd_issue |=> s_word) else $error("read sequence broken");
  a_single_bus: assert property (
    !dual_q && $past(!dual_q) |-> !tgt_bus)
    else $error("second bus used in single mode");
  a_bus_alt: assert property (
    xfer_done_q && dual_q && $stable(dual_q) && $stable(drv_per_bus)
    |=> tgt_bus != $past(tgt_bus)) else $error("bus did not alternate");
  a_drive_range: assert property (
    tgt_drive >= 4'h1 && tgt_drive <= 4'h8)
    else $error("drive out of range");
  a_no_disk: assert property (
    blk_done && !rec_q |=> !full_q[$past(fill_q)])
    else $error("unrecorded page queued");
  a_page_len: assert property (
    wc_q < PG_WORDS) else $error("page overrun");

endmodule : rbsm_top

// File: rbsm_disk_sink.sv
`timescale 1ns/1ps
module rbsm_disk_sink import rbsm_pkg::*; (
  // Clock
  input wire logic mclk,
  // Behaviour controls from the bench
  input wire logic [1:0] ready_en,
  input wire logic slow,
  // Disk paths
  input wire rbsm_disk_type [1:0] dk_out,
  output logic [1:0] drv_ready,
  output logic [1:0] dk_ready
);
  // ------------------------------------------------------------
  // Sink state
  // ------------------------------------------------------------
  logic ph_q = 1'b0;
  logic [31:0] words [0:1][0:15];
  logic lasts [0:1][0:15];
  int cnt [0:1] = '{0, 0};

  assign drv_ready = ready_en;
  // Slow sink takes a word only every other cycle
  assign dk_ready = (slow && ph_q) ? 2'h0 : 2'h3;

  // Stall phase
  always @(posedge mclk) begin
    ph_q <= ~ph_q;
  end

  // Capture of each word taken, per bus
  always @(posedge mclk) begin
    for (int b = 0; b < 2; b++) begin
      if (dk_out[b].valid === 1'b1 && dk_ready[b]) begin
        words[b][cnt[b][3:0]] <= dk_out[b].data;
        lasts[b][cnt[b][3:0]] <= dk_out[b].last;
        cnt[b] <= cnt[b] + 1;
      end
    end
  end
endmodule : rbsm_disk_sink

// File: record_buffer_striping_manager_tb.sv
`timescale 1ns/1ps
module record_buffer_striping_manager_tb import rbsm_pkg::*;;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, st;
  logic [16:0] rec_len;
  logic [15:0] msg_len, ts_data;
  logic [2:0] drv_per_bus;
  logic ts_valid, hr_req, hr_valid, xfer_go, xfer_done, tgt_bus;
  logic [31:0] ts_time, hr_data, mm_page_addr;
  rbsm_hwr_type host_wr;
  logic [17:0] hr_addr;
  logic [1:0] drv_ready, dk_ready, ready_en;
  rbsm_disk_type [1:0] dk_out;
  logic [3:0] tgt_drive, k;
  logic blk_irq, host_irq, slow;
  int failures = 0;
  int checked = 0;
  int nblk = 0;
  int nhost = 0;

  // ------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------
  always #4 mclk = ~mclk;

  rbsm_top uut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rec_len(rec_len), .msg_len(msg_len),
    .drv_per_bus(drv_per_bus), .ts_valid(ts_valid), .ts_data(ts_data),
    .ts_time(ts_time), .host_wr(host_wr), .hr_req(hr_req),
    .hr_addr(hr_addr), .hr_valid(hr_valid), .hr_data(hr_data),
    .xfer_go(xfer_go), .drv_ready(drv_ready), .dk_ready(dk_ready),
    .dk_out(dk_out), .xfer_done(xfer_done), .tgt_bus(tgt_bus),
    .tgt_drive(tgt_drive), .blk_irq(blk_irq), .host_irq(host_irq),
    .mm_page_addr(mm_page_addr));

  rbsm_disk_sink sink (.mclk(mclk), .ready_en(ready_en), .slow(slow),
    .dk_out(dk_out), .drv_ready(drv_ready), .dk_ready(dk_ready));

  // Event pulse counters
  always @(posedge mclk) begin
    if (blk_irq === 1'b1) nblk++;
    if (host_irq === 1'b1) nhost++;
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task tick;
    @(posedge mclk);
    #1;
  endtask : tick

  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task tally_and_finish;
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task reg_write(input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = RBSM_CMD_OFS;
    reg_wdata = d;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask : reg_write

  task reg_read(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    tick;
    reg_rd = 1'b0;
    st = reg_rdata;
    tick;
  endtask : reg_read

  // Host block of exactly the record length
  task send_block(input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      host_wr = '{1'b1, 18'(i), {24'hA00000, b, 4'(i)}};
      tick;
    end
    host_wr.valid = 1'b0;
    repeat (3) tick;
  endtask : send_block

  // Start a disk transfer and compare what reached the bus
  task transfer(input logic [3:0] b, input int bus);
    int old, n;
    old = sink.cnt[bus];
    xfer_go = 1'b1;
    for (n = 0; n < 200 && xfer_done !== 1'b1; n++) tick;
    xfer_go = 1'b0;
    if (n == 200) begin
      failures++;
      tally_and_finish;
    end
    repeat (2) tick;
    for (int i = 0; i < 4; i++) begin
      check(sink.words[bus][4'(old + i)], {24'hA00000, b, 4'(i)});
    end
    check(sink.lasts[bus][4'(old + 3)], 1);
    check(sink.cnt[bus], old + 4);
  endtask : transfer

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    rec_len = 17'h00004;
    msg_len = 16'h0002;
    drv_per_bus = 3'h2;
    ts_valid = 1'b0;
    ts_data = 16'h0000;
    ts_time = 32'h0;
    host_wr = '0;
    hr_req = 1'b0;
    hr_addr = 18'h0;
    xfer_go = 1'b0;
    ready_en = 2'h3;
    slow = 1'b0;
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (3) tick;
    // Reset state and unmapped read
    reg_read(RBSM_CMD_OFS);
    check(st, RBSM_CMD_RST);
    reg_read(8'h08);
    check(st, 16'h0000);
    check(tgt_drive, 4'h1);
    // Enable, dual bus, host source; then record on
    reg_write(16'h0019);
    reg_read(RBSM_CMD_OFS);
    check(st, 16'h0019);
    reg_write(16'h001B);
    reg_read(RBSM_CMD_OFS);
    check(st, 16'h0099);
    // Blocks alternate bus one drive 1, bus two drive 2, ...
    for (k = 4'h0; k < 4'h3; k++) begin
      send_block(k);
      check(nblk, k + 1);
      check(nhost, k + 1);
      reg_read(RBSM_CMD_OFS);
      check(st[12], 1);
      if (k == 4'h0) begin
        hr_req = 1'b1;
        tick;
        hr_req = 1'b0;
        check(hr_valid, 1);
        check(hr_data, 32'hA0000000);
      end
      if (k == 4'h1) begin
        ready_en = 2'h1;
        xfer_go = 1'b1;
        repeat (10) tick;
        xfer_go = 1'b0;
        check(sink.cnt[1], 0);
        ready_en = 2'h3;
        slow = 1'b1;
      end
      check({tgt_bus, tgt_drive}, {k[0], k + 4'h1});
      transfer(k, k[0]);
      slow = 1'b0;
    end
    // Record off: next completed block still goes to disk
    reg_write(16'h001D);
    send_block(4'h3);
    check({tgt_bus, tgt_drive}, 5'h14);
    transfer(4'h3, 1);
    reg_read(RBSM_CMD_OFS);
    check({st[12], st[7]}, 0);
    // Later block lands in memory but never on disk
    send_block(4'h4);
    check(nblk, 5);
    xfer_go = 1'b1;
    repeat (20) tick;
    xfer_go = 1'b0;
    check(sink.cnt[0] + sink.cnt[1], 16);
    // Single bus: record on again, no alternation
    reg_write(16'h0013);
    for (k = 4'h5; k < 4'h7; k++) begin
      send_block(k);
      check({tgt_bus, tgt_drive[0]}, 2'h1);
      transfer(k, 0);
    end
    check(mm_page_addr, 32'h000C0000);
    // Telemetry source: two 2-word messages form one record
    reg_write(16'h0003);
    for (int i = 0; i < 4; i++) begin
      ts_valid = 1'b1;
      ts_time = {28'hA000007, 4'(i & 2)};
      ts_data = i[0] ? 16'hA000 : {12'h007, 4'(i + 1)};
      tick;
    end
    ts_valid = 1'b0;
    repeat (3) tick;
    transfer(4'h7, 0);
    // Memory-mapped host writes: recorded, no host event
    reg_write(16'h0033);
    send_block(4'h8);
    transfer(4'h8, 0);
    check(nhost, 7);
    check(nblk, 9);
    // No free page: words dropped, overflow sticks until cleared
    for (k = 4'h9; k < 4'hE; k++) begin
      send_block(k);
    end
    reg_read(RBSM_CMD_OFS);
    check({st[13:12], st[6]}, 3'h7);
    reg_write(16'h0071);
    reg_read(RBSM_CMD_OFS);
    check({st[13], st[6]}, 2'h2);
    tally_and_finish;
  end
endmodule : record_buffer_striping_manager_tb
